// [rtl/charge_seq_pkg.sv]
// Timing constants, rate encoding and state set of the charge sequencer
package charge_seq_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_HZ          = 50000000;
  localparam int MS_PER_S        = 1000;
  localparam int MS_TICK_DEFAULT = CLK_HZ / MS_PER_S;  // Clock cycles per millisecond

  // ==========================================================================
  // Durations in their own units
  // ==========================================================================
  localparam int POLL_PULSE_MS   = 100;
  localparam int POLL_PERIOD_MS  = 624;
  localparam int REMOVE_WIN_MS   = 4;
  localparam int SOFT_INIT_MS    = 200;
  localparam int SOFT_STEP_MS    = 7;
  localparam int FAST_PULSE_MS   = 1048;
  localparam int REST_US         = 13000;
  localparam int ACQ_US          = 16400;
  localparam int TOP_MIN_MIN     = 120;
  localparam int TOP_4C_S        = 41;
  localparam int TOP_1C_S        = 11;
  localparam int TOP_C25_S       = 5;
  localparam int MAINT_4C_S      = 161;
  localparam int MAINT_1C_S      = 41;
  localparam int MAINT_C25_S     = 17;
  localparam int FAST_4C_MIN     = 21;
  localparam int FAST_1C_MIN     = 75;
  localparam int FAST_C25_MIN    = 212;
  localparam int MS_PER_MIN      = 60000;

  // ==========================================================================
  // Millisecond counts derived from the durations
  // ==========================================================================
  localparam int CW = 24;
  localparam logic [CW-1:0] POLL_ON_CNT   = CW'(POLL_PULSE_MS);
  localparam logic [CW-1:0] POLL_OFF_CNT  = CW'(POLL_PERIOD_MS - POLL_PULSE_MS);
  localparam logic [CW-1:0] WIN_CNT       = CW'(REMOVE_WIN_MS);
  localparam logic [CW-1:0] SOFT_INIT_CNT = CW'(SOFT_INIT_MS);
  localparam logic [CW-1:0] SOFT_STEP_CNT = CW'(SOFT_STEP_MS);
  localparam logic [CW-1:0] FAST_ON_CNT   = CW'(FAST_PULSE_MS);
  localparam logic [CW-1:0] FAST_OFF_CNT  = CW'((REST_US + ACQ_US) / MS_PER_S);
  localparam logic [CW-1:0] TOP_MIN_CNT   = CW'(TOP_MIN_MIN * MS_PER_MIN);
  localparam logic [CW-1:0] TOP_4C_CNT    = CW'(TOP_4C_S * MS_PER_S - FAST_PULSE_MS);
  localparam logic [CW-1:0] TOP_1C_CNT    = CW'(TOP_1C_S * MS_PER_S - FAST_PULSE_MS);
  localparam logic [CW-1:0] TOP_C25_CNT   = CW'(TOP_C25_S * MS_PER_S - FAST_PULSE_MS);
  localparam logic [CW-1:0] MAINT_4C_CNT  = CW'(MAINT_4C_S * MS_PER_S - FAST_PULSE_MS);
  localparam logic [CW-1:0] MAINT_1C_CNT  = CW'(MAINT_1C_S * MS_PER_S - FAST_PULSE_MS);
  localparam logic [CW-1:0] MAINT_C25_CNT = CW'(MAINT_C25_S * MS_PER_S - FAST_PULSE_MS);
  localparam logic [CW-1:0] FAST_4C_CNT   = CW'(FAST_4C_MIN * MS_PER_MIN);
  localparam logic [CW-1:0] FAST_1C_CNT   = CW'(FAST_1C_MIN * MS_PER_MIN);
  localparam logic [CW-1:0] FAST_C25_CNT  = CW'(FAST_C25_MIN * MS_PER_MIN);

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [1:0] {RATE_4C, RATE_1C, RATE_C25} rate_e;

  typedef enum logic [3:0] {
    ST_POWER_UP, ST_POLL_ON, ST_POLL_OFF, ST_SOFT_ON, ST_SOFT_OFF,
    ST_FAST_ON, ST_FAST_OFF, ST_TOP_ON, ST_TOP_OFF, ST_MAINT_ON,
    ST_MAINT_OFF, ST_SHUTDOWN
  } state_e;

endpackage : charge_seq_pkg

// [rtl/battery_charge_sequencer.sv]
// Pulsed-current charge sequencer: polling, soft start, fast, topping, maintenance
`timescale 1ns/1ns
`default_nettype none

module battery_charge_sequencer
  import charge_seq_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_TICK_DEFAULT
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Comparator front end
  input  wire logic cell_above_open_circuit_reference,
  input  wire logic cell_below_half,
  input  wire logic open_circuit_reference_over_2v3,
  input  wire logic open_circuit_reference_over_4v,
  input  wire logic rate_pin_low,
  input  wire logic rate_pin_mid,
  input  wire logic slope_done,
  // Current source switch
  output var  logic charge_pulse_out,
  // Open-drain indicators
  output var  logic fast_charge_indicator_out,
  output var  logic fast_charge_indicator_oe_n,
  output var  logic maintenance_indicator_out,
  output var  logic maintenance_indicator_oe_n
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Topping off time for the latched rate
  function automatic logic [CW-1:0] top_off(input rate_e r);
    case (r)
      RATE_4C:  top_off = TOP_4C_CNT;
      RATE_C25: top_off = TOP_C25_CNT;
      default:  top_off = TOP_1C_CNT;
    endcase
  endfunction : top_off

  // Maintenance off time for the latched rate
  function automatic logic [CW-1:0] maint_off(input rate_e r);
    case (r)
      RATE_4C:  maint_off = MAINT_4C_CNT;
      RATE_C25: maint_off = MAINT_C25_CNT;
      default:  maint_off = MAINT_1C_CNT;
    endcase
  endfunction : maint_off

  // Fast charge time limit for the latched rate
  function automatic logic [CW-1:0] fast_limit(input rate_e r);
    case (r)
      RATE_4C:  fast_limit = FAST_4C_CNT;
      RATE_C25: fast_limit = FAST_C25_CNT;
      default:  fast_limit = FAST_1C_CNT;
    endcase
  endfunction : fast_limit

  // States in which the current source is switched on
  function automatic logic is_on(input state_e s);
    is_on = (s == ST_POLL_ON) || (s == ST_SOFT_ON) || (s == ST_FAST_ON) ||
            (s == ST_TOP_ON) || (s == ST_MAINT_ON);
  endfunction : is_on

  // ==========================================================================
  // Millisecond time base
  // ==========================================================================
  logic [16:0]   tick_cnt_reg;
  logic          ms_tick_reg;
  state_e        state_reg;
  state_e        state_next;
  rate_e         rate_reg;
  logic [CW-1:0] phase_reg;
  logic [CW-1:0] soft_width_reg;
  logic [CW-1:0] session_reg;
  logic [CW-1:0] stage_reg;
  logic          seen_above_reg;
  logic          in_window;
  logic          phase_end;
  logic          session_start;
  logic          keep_phase;

  // Every duration below counts this one tick, so all scale with the clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg == 17'(MS_TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      ms_tick_reg  <= 1'b0;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign in_window     = is_on(state_reg) && (phase_reg < WIN_CNT);
  assign session_start = ((state_reg == ST_POWER_UP) || (state_reg == ST_POLL_ON)) &&
                         (state_next == ST_SOFT_ON);
  // The detecting poll pulse carries on as the first soft-start pulse
  assign keep_phase    = (state_reg == ST_POLL_ON) && (state_next == ST_SOFT_ON);

  // Phase end for the current state's duration, checked on the tick
  always_comb begin
    logic [CW-1:0] dur;
    dur = FAST_OFF_CNT;
    case (state_reg)
      ST_POLL_ON:   dur = POLL_ON_CNT;
      ST_POLL_OFF:  dur = POLL_OFF_CNT;
      ST_SOFT_ON:   dur = soft_width_reg;
      ST_FAST_ON,
      ST_TOP_ON,
      ST_MAINT_ON:  dur = FAST_ON_CNT;
      ST_TOP_OFF:   dur = top_off(rate_reg);
      ST_MAINT_OFF: dur = maint_off(rate_reg);
      default:      dur = FAST_OFF_CNT;
    endcase
    phase_end = ms_tick_reg && (phase_reg >= dur - 24'h000001);
  end

  // Next state; shutdown overrides everything and is only left by reset
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POWER_UP:
        state_next = cell_below_half ? ST_POLL_ON : ST_SOFT_ON;
      ST_POLL_ON: begin
        if (seen_above_reg || (in_window && cell_above_open_circuit_reference)) begin
          if (phase_end) state_next = ST_POLL_OFF;
        end else if (!in_window) begin
          state_next = ST_SOFT_ON;
        end
      end
      ST_POLL_OFF:
        if (phase_end) state_next = ST_POLL_ON;
      ST_SOFT_ON:
        if (in_window && cell_above_open_circuit_reference) state_next = ST_POLL_OFF;
        else if (phase_end) state_next = ST_SOFT_OFF;
      ST_SOFT_OFF:
        if (phase_end) begin
          if ((soft_width_reg >= FAST_ON_CNT) && !open_circuit_reference_over_2v3) state_next = ST_FAST_ON;
          else state_next = ST_SOFT_ON;
        end
      ST_FAST_ON:
        if (in_window && cell_above_open_circuit_reference) state_next = ST_POLL_OFF;
        else if (session_reg >= fast_limit(rate_reg)) state_next = ST_TOP_OFF;
        else if (phase_end) state_next = ST_FAST_OFF;
      ST_FAST_OFF:
        if ((session_reg >= fast_limit(rate_reg)) || slope_done) state_next = ST_TOP_OFF;
        else if (phase_end) state_next = ST_FAST_ON;
      ST_TOP_ON:
        if (in_window && cell_above_open_circuit_reference) state_next = ST_POLL_OFF;
        else if (phase_end) state_next = ST_TOP_OFF;
      ST_TOP_OFF:
        if (cell_below_half) state_next = ST_POLL_OFF;
        else if (phase_end) state_next = (stage_reg >= TOP_MIN_CNT) ? ST_MAINT_ON : ST_TOP_ON;
      ST_MAINT_ON:
        if (in_window && cell_above_open_circuit_reference) state_next = ST_POLL_OFF;
        else if (phase_end) state_next = ST_MAINT_OFF;
      ST_MAINT_OFF:
        if (cell_below_half) state_next = ST_POLL_OFF;
        else if (phase_end) state_next = ST_MAINT_ON;
      ST_SHUTDOWN:
        state_next = ST_SHUTDOWN;
      default:
        state_next = ST_POWER_UP;
    endcase
    if (open_circuit_reference_over_4v) state_next = ST_SHUTDOWN;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) state_reg <= ST_POWER_UP;
    else state_reg <= state_next;
  end

  // Time spent in the current phase
  always_ff @(posedge clk) begin
    if (sys_rst) phase_reg <= '0;
    else if ((state_next != state_reg) && !keep_phase) phase_reg <= '0;
    else if (ms_tick_reg) phase_reg <= phase_reg + 24'h000001;
  end

  // Absence seen inside the window of a poll pulse; the pulse still runs full length
  always_ff @(posedge clk) begin
    if (sys_rst) seen_above_reg <= 1'b0;
    else if (state_reg != ST_POLL_ON) seen_above_reg <= 1'b0;
    else if (in_window && cell_above_open_circuit_reference) seen_above_reg <= 1'b1;
  end

  // Soft-start pulse grows each cycle until it matches the fast pulse
  always_ff @(posedge clk) begin
    if (sys_rst) soft_width_reg <= SOFT_INIT_CNT;
    else if (session_start) soft_width_reg <= SOFT_INIT_CNT;
    else if ((state_reg == ST_SOFT_OFF) && (state_next == ST_SOFT_ON)) begin
      if (soft_width_reg + SOFT_STEP_CNT >= FAST_ON_CNT) soft_width_reg <= FAST_ON_CNT;
      else soft_width_reg <= soft_width_reg + SOFT_STEP_CNT;
    end
  end

  // Rate is read off the indicator pin while it is still released
  always_ff @(posedge clk) begin
    if (sys_rst) rate_reg <= RATE_1C;
    else if (session_start) begin
      if (rate_pin_low) rate_reg <= RATE_4C;
      else if (rate_pin_mid) rate_reg <= RATE_C25;
      else rate_reg <= RATE_1C;
    end
  end

  // Session timer from power-up or insertion; saturates so it cannot wrap
  always_ff @(posedge clk) begin
    if (sys_rst) session_reg <= '0;
    else if (session_start) session_reg <= '0;
    else if (ms_tick_reg && (session_reg != '1)) session_reg <= session_reg + 24'h000001;
  end

  // Topping stage timer, gives the minimum topping time
  always_ff @(posedge clk) begin
    if (sys_rst) stage_reg <= '0;
    else if ((state_next == ST_TOP_OFF) && (state_reg != ST_TOP_OFF) && (state_reg != ST_TOP_ON)) stage_reg <= '0;
    else if (ms_tick_reg && (stage_reg != '1)) stage_reg <= stage_reg + 24'h000001;
  end

  // ==========================================================================
  // Pin drivers, registered from the next state so they track state_reg
  // ==========================================================================
  // Switching is the only current control; the source sets the amplitude
  always_ff @(posedge clk) begin
    if (sys_rst) charge_pulse_out <= 1'b0;
    else charge_pulse_out <= is_on(state_next);
  end

  // Open drains only ever pull low, so the data flops stay at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fast_charge_indicator_out <= 1'b0;
      maintenance_indicator_out <= 1'b0;
    end else begin
      fast_charge_indicator_out <= 1'b0;
      maintenance_indicator_out <= 1'b0;
    end
  end

  // Enables are low while the pin is pulled low, released otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fast_charge_indicator_oe_n <= 1'b1;
      maintenance_indicator_oe_n <= 1'b1;
    end else begin
      fast_charge_indicator_oe_n <= !((state_next == ST_SOFT_ON) || (state_next == ST_SOFT_OFF) ||
                                      (state_next == ST_FAST_ON) || (state_next == ST_FAST_OFF));
      maintenance_indicator_oe_n <= !((state_next == ST_POWER_UP) || (state_next == ST_POLL_ON) ||
                                      (state_next == ST_POLL_OFF) || (state_next == ST_TOP_ON) ||
                                      (state_next == ST_TOP_OFF) || (state_next == ST_MAINT_ON) ||
                                      (state_next == ST_MAINT_OFF));
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_removed_in_window;
    is_on(state_reg) && (state_reg != ST_POLL_ON) && in_window && cell_above_open_circuit_reference && !open_circuit_reference_over_4v;
  endsequence

  sequence s_went_polling;
    (state_reg == ST_POLL_OFF) && !charge_pulse_out;
  endsequence

  a_pulse_drive: assert property (charge_pulse_out == is_on(state_reg))
    else $error("charge pulse does not match state");
  a_od_low_only: assert property (!fast_charge_indicator_out && !maintenance_indicator_out)
    else $error("open-drain data not low");
  a_fast_ind_on: assert property (((state_reg == ST_SOFT_ON) || (state_reg == ST_FAST_OFF)) |->
                                  !fast_charge_indicator_oe_n)
    else $error("fast indicator released during fast charge");
  a_top_release: assert property ((state_reg == ST_FAST_OFF) ##1 (state_reg == ST_TOP_OFF) |->
                                  fast_charge_indicator_oe_n && !maintenance_indicator_oe_n)
    else $error("fast indicator not released at topping");
  a_maint_ind_on: assert property (((state_reg == ST_TOP_OFF) || (state_reg == ST_MAINT_ON) ||
                                    (state_reg == ST_POLL_ON)) |-> !maintenance_indicator_oe_n)
    else $error("maintenance indicator not asserted");
  a_removal_poll: assert property (s_removed_in_window |=> s_went_polling)
    else $error("removal in window not taken to polling");
  a_open_circuit_reference_block: assert property (((state_reg == ST_SOFT_OFF) && open_circuit_reference_over_2v3) |=> (state_reg != ST_FAST_ON))
    else $error("fast charge started with high reference");
  a_shutdown_hold: assert property ((open_circuit_reference_over_4v ##1 1'b1) |-> (state_reg == ST_SHUTDOWN) ##1
                                    ((state_reg == ST_SHUTDOWN) && !charge_pulse_out))
    else $error("shutdown not entered or not held");
  a_rate_hold: assert property (!session_start |=> $stable(rate_reg))
    else $error("rate changed inside a session");
  a_idle_removal: assert property (((state_reg == ST_MAINT_OFF) && cell_below_half && !open_circuit_reference_over_4v) |=>
                                   (state_reg == ST_POLL_OFF))
    else $error("low cell between pulses not taken to polling");

endmodule : battery_charge_sequencer

`default_nettype wire

// [tb/charge_partner_model.sv]
// Behavioural battery, current source and indicator strap model for the sequencer bench
`timescale 1ns/1ns
`default_nettype none

module charge_partner_model (
  // Switch and indicator pin from the sequencer
  input  wire logic       charge_pulse_out,
  input  wire logic       fast_charge_indicator_out,
  input  wire logic       fast_charge_indicator_oe_n,
  // Bench controls
  input  wire logic       battery_present,
  input  wire logic [1:0] rate_cfg,
  // Comparator front end outputs
  output var  logic       cell_above_open_circuit_reference,
  output var  logic       cell_below_half,
  output var  logic       rate_pin_low,
  output var  logic       rate_pin_mid
);
  // ==========================================================================
  // Cell node
  // ==========================================================================
  // Source amplitude is fixed outside; an open source lifts the node over the reference
  always_comb begin
    cell_above_open_circuit_reference = charge_pulse_out && !battery_present;
    cell_below_half  = !charge_pulse_out && !battery_present;
  end

  // ==========================================================================
  // Indicator strap
  // ==========================================================================
  // A released pin shows the strap level; a pulled pin reads as ground
  always_comb begin
    if (!fast_charge_indicator_oe_n) begin
      rate_pin_low = !fast_charge_indicator_out;
      rate_pin_mid = 1'b0;
    end else begin
      rate_pin_low = (rate_cfg == 2'h0);
      rate_pin_mid = (rate_cfg == 2'h2);
    end
  end
endmodule : charge_partner_model
`default_nettype wire

// [tb/battery_charge_sequencer_test.sv]
// Self-checking bench for the charge sequencer: polling, insertion, soft start, removal, shutdown
`timescale 1ns/1ns
`default_nettype none

module battery_charge_sequencer_test;
  import charge_seq_pkg::*;
  // Short time base keeps the run small; every width scales with it
  localparam int TICK = 5;
  localparam int LIM  = 20000;

  logic       clk, sys_rst, cell_above_open_circuit_reference, cell_below_half, open_circuit_reference_over_2v3, open_circuit_reference_over_4v;
  logic       rate_pin_low, rate_pin_mid, slope_done, charge_pulse_out;
  logic       fast_charge_indicator_out, fast_charge_indicator_oe_n;
  logic       maintenance_indicator_out, maintenance_indicator_oe_n;
  logic       battery_present;
  logic [1:0] rate_cfg;
  int         fail_count, checked, seed, n;

  // ==========================================================================
  // Design and far side
  // ==========================================================================
  battery_charge_sequencer #(.MS_TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .cell_above_open_circuit_reference(cell_above_open_circuit_reference), .cell_below_half(cell_below_half),
    .open_circuit_reference_over_2v3(open_circuit_reference_over_2v3), .open_circuit_reference_over_4v(open_circuit_reference_over_4v), .rate_pin_low(rate_pin_low),
    .rate_pin_mid(rate_pin_mid), .slope_done(slope_done), .charge_pulse_out(charge_pulse_out),
    .fast_charge_indicator_out(fast_charge_indicator_out),
    .fast_charge_indicator_oe_n(fast_charge_indicator_oe_n),
    .maintenance_indicator_out(maintenance_indicator_out),
    .maintenance_indicator_oe_n(maintenance_indicator_oe_n));

  charge_partner_model u_partner (
    .charge_pulse_out(charge_pulse_out), .fast_charge_indicator_out(fast_charge_indicator_out),
    .fast_charge_indicator_oe_n(fast_charge_indicator_oe_n), .battery_present(battery_present),
    .rate_cfg(rate_cfg), .cell_above_open_circuit_reference(cell_above_open_circuit_reference), .cell_below_half(cell_below_half),
    .rate_pin_low(rate_pin_low), .rate_pin_mid(rate_pin_mid));

  // Square clock, well inside the allowed duty band
  always #10 clk = ~clk;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Inputs move a fixed 2 ns after the edge, outputs are read there too
  task automatic step();
    @(posedge clk);
    #2;
  endtask : step

  // Count cycles while the switch holds a level; a stuck level ends the run
  task automatic run(input logic v, output int cnt);
    cnt = 0;
    while (charge_pulse_out === v && cnt < LIM) begin
      step();
      cnt++;
    end
    if (cnt >= LIM) begin
      check(32'(cnt), 32'(v));
      end_of_test();
    end
  endtask : run

  // Width in ms, allowing the one-tick phase jitter and output registration
  function automatic logic [31:0] as_ms(input int cnt, input int ms);
    if (cnt >= ms * TICK - 2 && cnt <= (ms + 1) * TICK + 2) return 32'(ms);
    return 32'(cnt / TICK);
  endfunction : as_ms

  // Indicator view: fast oe_n, maint oe_n, fast data, maint data
  function automatic logic [31:0] ind();
    return {28'h0, fast_charge_indicator_oe_n, maintenance_indicator_oe_n,
            fast_charge_indicator_out, maintenance_indicator_out};
  endfunction : ind

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) step();
    check({27'h0, charge_pulse_out, ind()}, 32'h0c);
    sys_rst = 1'b0;
  endtask : do_reset

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    open_circuit_reference_over_4v = 1'b0;
    battery_present = 1'b0;
    fail_count = 0;
    checked = 0;
    seed = 89437;
    rate_cfg = 2'($unsigned($random(seed)) % 3);
    open_circuit_reference_over_2v3 = 1'($random(seed));
    slope_done = 1'($random(seed));
    do_reset();

    // Polling with no battery, insertion during the third gap
    repeat (2) step();
    check(ind(), 32'h8);
    run(1'b1, n);
    run(1'b0, n);
    for (int i = 0; i < 2; i++) begin
      run(1'b1, n);
      check(as_ms(n, POLL_PULSE_MS), 32'(POLL_PULSE_MS));
      if (i == 1) begin
        repeat (10 + $unsigned($random(seed)) % 400) step();
        battery_present = 1'b1;
      end
      run(1'b0, n);
      if (i == 0) check(as_ms(n, POLL_PERIOD_MS - POLL_PULSE_MS), 32'(POLL_PERIOD_MS - POLL_PULSE_MS));
    end
    $display("polling test done");

    // Detected pulse is still a poll pulse through the sense window, then turns into soft start
    step();
    check(ind(), 32'h8);
    repeat ((REMOVE_WIN_MS + 1) * TICK) step();
    check(ind(), 32'h4);
    run(1'b1, n);
    check(as_ms(n + 1 + (REMOVE_WIN_MS + 1) * TICK, SOFT_INIT_MS), 32'(SOFT_INIT_MS));
    run(1'b0, n);
    check(as_ms(n, (REST_US + ACQ_US) / MS_PER_S), 32'((REST_US + ACQ_US) / MS_PER_S));
    run(1'b1, n);
    check(as_ms(n, SOFT_INIT_MS + SOFT_STEP_MS), 32'(SOFT_INIT_MS + SOFT_STEP_MS));
    $display("soft start test done");

    // Removal in the gap: next pulse is cut inside the sense window
    battery_present = 1'b0;
    run(1'b0, n);
    run(1'b1, n);
    check(32'(n <= (REMOVE_WIN_MS + 1) * TICK + 2), 32'h1);
    check(ind(), 32'h8);
    run(1'b0, n);
    check(as_ms(n, POLL_PERIOD_MS - POLL_PULSE_MS), 32'(POLL_PERIOD_MS - POLL_PULSE_MS));
    $display("removal test done");

    // Gross reference over range: everything off and stays off
    open_circuit_reference_over_4v = 1'b1;
    repeat (3) step();
    open_circuit_reference_over_4v = 1'b0;
    battery_present = 1'b1;
    n = 0;
    repeat (2000) begin
      step();
      if (charge_pulse_out !== 1'b0 || ind() !== 32'hc) n++;
    end
    check(32'(n), 32'h0);
    $display("shutdown test done");

    // Restart with a battery fitted goes straight to soft start
    do_reset();
    repeat (2) step();
    check({31'h0, charge_pulse_out}, 32'h1);
    check(ind(), 32'h4);
    run(1'b1, n);
    check(as_ms(n + 1, SOFT_INIT_MS), 32'(SOFT_INIT_MS));
    $display("restart test done");
    end_of_test();
  end
endmodule : battery_charge_sequencer_test
`default_nettype wire
